// >>> rtl/ocsv_consts.vh
// Constants for the output channel status voting block
`ifndef OCSV_CONSTS_VH
`define OCSV_CONSTS_VH
`define OCSV_NUM_CHAN      40
`define OCSV_NUM_SLICE     3
`define OCSV_MEM_DEPTH     120
`define OCSV_DATA_W        16
`define OCSV_STATE_W       3
`define OCSV_HK_QTY        19
`define OCSV_HK_COUNT      57
`define OCSV_WORD_W        16
`define OCSV_WORD2_USED    8
`define OCSV_ST_UNUSED     3'h0
`define OCSV_ST_NO_SUPPLY  3'h1
`define OCSV_ST_OFF        3'h2
`define OCSV_ST_OPEN       3'h3
`define OCSV_ST_ON         3'h4
`define OCSV_ST_SHORT      3'h5
`define OCSV_ST_FIELD      3'h6
`define OCSV_SAT_MAX       16'h7fff
`define OCSV_SAT_MIN       16'h8000
`define OCSV_ALL_DONE      3'h7
`define OCSV_BASE_A        7'h00
`define OCSV_BASE_B        7'h28
`define OCSV_BASE_C        7'h50
`endif

// >>> rtl/ocsv_chan_vote.v
// Per-channel voter: state majority, voltage median, saturating current sum and two-of-three line fault
`timescale 1ns/1ps
`include "ocsv_consts.vh"
module ocsv_chan_vote
(
  // Slice contributions
  input  wire [2:0]         stateA,
  input  wire [2:0]         stateB,
  input  wire [2:0]         stateC,
  input  wire signed [15:0] voltA,
  input  wire signed [15:0] voltB,
  input  wire signed [15:0] voltC,
  input  wire signed [15:0] currA,
  input  wire signed [15:0] currB,
  input  wire signed [15:0] currC,
  // Voted results
  output reg  [2:0]         stateVote,
  output wire               disagree,
  output wire [15:0]        voltMedian,
  output reg  [15:0]        currSum,
  output wire               faultVote
);
  wire signed [15:0] loAB;
  wire signed [15:0] hiAB;
  wire signed [15:0] loHiC;
  wire signed [17:0] sumWide;
  wire               faultA;
  wire               faultB;
  wire               faultC;

  always @*
  begin
    if (stateA == stateB || stateA == stateC)
      stateVote = stateA;
    else if (stateB == stateC)
      stateVote = stateB;
    else
      stateVote = stateA; // No majority: slice A kept, flagged below
  end

  assign disagree = (stateA != stateB) || (stateB != stateC);

  // Median = max(min(a,b), min(max(a,b),c))
  assign loAB       = (voltA < voltB) ? voltA : voltB;
  assign hiAB       = (voltA < voltB) ? voltB : voltA;
  assign loHiC      = (hiAB < voltC) ? hiAB : voltC;
  assign voltMedian = (loAB > loHiC) ? loAB : loHiC;

  assign sumWide = {{2{currA[15]}}, currA} + {{2{currB[15]}}, currB} + {{2{currC[15]}}, currC};

  // Saturate rather than wrap so an overload never reads as a reversed current
  always @*
  begin
    if (sumWide > 18'sh07fff)
      currSum = `OCSV_SAT_MAX;
    else if (sumWide < -18'sh08000)
      currSum = `OCSV_SAT_MIN;
    else
      currSum = sumWide[15:0];
  end

  assign faultA = (stateA == `OCSV_ST_OPEN) || (stateA == `OCSV_ST_SHORT) || (stateA == `OCSV_ST_NO_SUPPLY);
  assign faultB = (stateB == `OCSV_ST_OPEN) || (stateB == `OCSV_ST_SHORT) || (stateB == `OCSV_ST_NO_SUPPLY);
  assign faultC = (stateC == `OCSV_ST_OPEN) || (stateC == `OCSV_ST_SHORT) || (stateC == `OCSV_ST_NO_SUPPLY);
  assign faultVote = (faultA & faultB) | (faultA & faultC) | (faultB & faultC);
endmodule // ocsv_chan_vote

// >>> rtl/ocsv_status_voter.v
// Output channel status voting: slice data capture, voting and housekeeping
// Contract
// - State code 6 field fault, 5 short circuit, 3 open circuit.
// - State code 1 no field supply, 4 energized, 2 de-energized, 0 unused.
// - Channel voltage is the median of the three slice voltages.
// - Voltage is signed, one step is 1/500 V.
// - Channel current is the sum of the three slice currents.
// - Current is signed, one step is one milliampere.
// - Line fault is one for open, short or missing field supply.
// - Reported line fault is a two-of-three vote of slice flags.
// - Discrepancy bits pack into three 16-bit words, lowest channel at bit 0.
// - Discrepancy bit is one when slices disagree on state code.
// - Housekeeping reported per slice A, B, C, signed 16-bit, supplies in mV.
// - Board temperature housekeeping divided by 256 gives degrees Celsius.
// - Group field supply housekeeping in signed steps of 1/500 V.
// - All five per-channel data sets cover channels 1 to 40.
// - Housekeeping of a fatal slice reads zero.
`timescale 1ns/1ps
`include "ocsv_consts.vh"
module ocsv_status_voter
(
  // Clock, reset, enable
  input  wire          clock,
  input  wire          rst,
  input  wire          ce,
  // Slice channel data
  input  wire          sliceWrite,
  input  wire [1:0]    sliceSel,
  input  wire [5:0]    sliceChan,
  input  wire [2:0]    sliceStateCode,
  input  wire [15:0]   sliceVolt,
  input  wire [15:0]   sliceCurr,
  input  wire          sliceScanDone,
  input  wire [2:0]    sliceFatal,
  // Slice housekeeping data
  input  wire          hkWrite,
  input  wire [1:0]    hkSel,
  input  wire [4:0]    hkQty,
  input  wire [15:0]   hkValue,
  // Published channel data
  output reg  [119:0]  chanStateCodes,
  output reg  [639:0]  voltageReadbackSet,
  output reg  [639:0]  currentReadbackSet,
  output reg  [39:0]   lineFaultFlags,
  output reg  [15:0]   sliceDisagreementWord0,
  output reg  [15:0]   sliceDisagreementWord1,
  output reg  [15:0]   sliceDisagreementWord2,
  output reg  [911:0]  housekeepingValues,
  output reg           scanUpdated
);
  localparam NCH = `OCSV_NUM_CHAN;
  localparam NHK = `OCSV_HK_COUNT;

  reg  [2:0]   stateMem [0:`OCSV_MEM_DEPTH-1];
  reg  [15:0]  voltMem  [0:`OCSV_MEM_DEPTH-1];
  reg  [15:0]  currMem  [0:`OCSV_MEM_DEPTH-1];
  reg  [2:0]   done_reg;
  reg  [2:0]   done_next;
  reg  [2:0]   doneSet;
  reg  [6:0]   sliceBase;
  wire [911:0] hk_next;
  wire [119:0] stateW;
  wire [639:0] voltW;
  wire [639:0] currW;
  wire [39:0]  faultW;
  wire [39:0]  discW;
  wire         selOk;
  wire         chanHit;
  wire         chanOk;
  wire [6:0]   memIdx;
  wire         hkSelOk;
  wire         hkQtyOk;
  wire         hkOk;
  wire [6:0]   hkIdx;
  wire         publish;
  wire [15:0]  discWord0;
  wire [15:0]  discWord1;
  wire [15:0]  discWord2;

  // Channels are numbered from one; index zero and above forty are dropped
  assign selOk   = (sliceSel < 2'h3);
  assign chanHit = (sliceChan != 6'h00) && (sliceChan <= 6'h28);
  assign chanOk  = sliceWrite && selOk && chanHit;
  assign memIdx  = sliceBase + {1'b0, sliceChan} - 7'h01;

  // Housekeeping entry sits at three times the quantity plus the slice
  assign hkSelOk = (hkSel < 2'h3);
  assign hkQtyOk = (hkQty < 5'h13);
  assign hkOk    = hkWrite && hkSelOk && hkQtyOk;
  assign hkIdx   = {2'h0, hkQty} * 7'h03 + {5'h00, hkSel};

  // All three slices reported this scan
  assign publish = (done_reg == `OCSV_ALL_DONE);

  // Fixed slice bases keep a multiplier out of the write path
  always @*
  begin
    case (sliceSel)
      2'h0:    sliceBase = `OCSV_BASE_A;
      2'h1:    sliceBase = `OCSV_BASE_B;
      2'h2:    sliceBase = `OCSV_BASE_C;
      default: sliceBase = `OCSV_BASE_A;
    endcase
  end

  // Slice scan memory; a slice must not start its next scan before publish
  always @(posedge clock)
  begin
    if (ce && chanOk)
    begin
      stateMem[memIdx] <= sliceStateCode;
      voltMem[memIdx]  <= sliceVolt;
      currMem[memIdx]  <= sliceCurr;
    end
  end

  genvar c;
  generate
    for (c = 0; c < NCH; c = c + 1)
    begin : gChan
      ocsv_chan_vote uVote
      (
        .stateA     (stateMem[c]),
        .stateB     (stateMem[NCH + c]),
        .stateC     (stateMem[2 * NCH + c]),
        .voltA      (voltMem[c]),
        .voltB      (voltMem[NCH + c]),
        .voltC      (voltMem[2 * NCH + c]),
        .currA      (currMem[c]),
        .currB      (currMem[NCH + c]),
        .currC      (currMem[2 * NCH + c]),
        .stateVote  (stateW[3 * c +: 3]),
        .disagree   (discW[c]),
        .voltMedian (voltW[16 * c +: 16]),
        .currSum    (currW[16 * c +: 16]),
        .faultVote  (faultW[c])
      );
    end
  endgenerate

  // Scan completion; a new done wins over the clear at publish
  always @*
  begin
    doneSet = 3'h0;
    if (sliceScanDone && selOk)
      doneSet[sliceSel] = 1'b1;
    if (publish)
      done_next = doneSet;
    else
      done_next = done_reg | doneSet;
  end

  // Per-entry housekeeping next value; a fatal slice wins over a write
  genvar k;
  generate
    for (k = 0; k < NHK; k = k + 1)
    begin : gHk
      wire hit;
      assign hit = hkOk && (hkIdx == k);
      assign hk_next[16 * k +: 16] = sliceFatal[k % 3] ? 16'h0000 :
                                     (hit ? hkValue : housekeepingValues[16 * k +: 16]);
    end
  endgenerate

  // Unmapped upper bits of the last word are tied low
  assign discWord0 = discW[15:0];
  assign discWord1 = discW[31:16];
  assign discWord2 = {8'h00, discW[39:32]};

  // Scan bookkeeping and the one-cycle publish pulse
  always @(posedge clock)
  begin
    if (rst)
    begin
      done_reg    <= 3'h0;
      scanUpdated <= 1'b0;
    end
    else if (ce)
    begin
      done_reg    <= done_next;
      scanUpdated <= publish;
    end
  end

  // Housekeeping register
  always @(posedge clock)
  begin
    if (rst)
      housekeepingValues <= 912'h0;
    else if (ce)
      housekeepingValues <= hk_next;
  end

  // Published channel data; moves only on a publish
  always @(posedge clock)
  begin
    if (rst)
    begin
      chanStateCodes         <= 120'h0;
      voltageReadbackSet     <= 640'h0;
      currentReadbackSet     <= 640'h0;
      lineFaultFlags         <= 40'h0;
      sliceDisagreementWord0 <= 16'h0000;
      sliceDisagreementWord1 <= 16'h0000;
      sliceDisagreementWord2 <= 16'h0000;
    end
    else if (ce && publish)
    begin
      chanStateCodes         <= stateW;
      voltageReadbackSet     <= voltW;
      currentReadbackSet     <= currW;
      lineFaultFlags         <= faultW;
      sliceDisagreementWord0 <= discWord0;
      sliceDisagreementWord1 <= discWord1;
      sliceDisagreementWord2 <= discWord2;
    end
  end
endmodule // ocsv_status_voter

// >>> tb/ocsv_status_voter_sva.sv
// Port assertions for the status voter
`timescale 1ns/1ps
module ocsv_sva (
  // Inputs
  input wire clock, rst, ce, sliceScanDone, hkWrite,
  input wire [2:0] sliceFatal,
  input wire [1:0] hkSel,
  input wire [4:0] hkQty,
  input wire [15:0] hkValue,
  // Outputs
  input wire scanUpdated,
  input wire [39:0] lineFaultFlags,
  input wire [639:0] voltageReadbackSet,
  input wire [15:0] sliceDisagreementWord2,
  input wire [911:0] housekeepingValues
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_pulse;
    scanUpdated ##1 !scanUpdated;
  endsequence
  a_pulse_single: assert property ($rose(scanUpdated) |-> s_pulse) else $error("long publish pulse");
  a_done_first: assert property ($rose(scanUpdated) |-> $past(sliceScanDone, 2)) else $error("publish w/o done");
  a_outputs_hold: assert property (
    !scanUpdated |-> $stable(lineFaultFlags) && $stable(voltageReadbackSet))
    else $error("outputs moved w/o publish");
  a_word2_upper: assert property (sliceDisagreementWord2[15:8] == 8'h00) else $error("word2 high bits set");
  a_fatal_a: assert property (
    ce && sliceFatal[0] |=> housekeepingValues[15:0] == 16'h0000)
    else $error("fatal A not zero");
  a_fatal_c: assert property (
    ce && sliceFatal[2] |=> housekeepingValues[479:464] == 16'h0000)
    else $error("fatal C not zero");
  a_hk_store: assert property (
    ce && hkWrite && hkSel < 3 && hkQty < 19 && !sliceFatal[hkSel] |=>
    housekeepingValues[16 * (3 * $past(hkQty) + $past(hkSel)) +: 16] == $past(hkValue))
    else $error("hk value not stored");
  a_ce_freeze: assert property (!ce |=> $stable(scanUpdated) && $stable(housekeepingValues))
    else $error("moved while frozen");
endmodule // ocsv_sva
bind ocsv_status_voter ocsv_sva u_sva (.*);

// >>> tb/ocsv_ctrl_poll.sv
// Controller side poller latching channel 1 readback
`timescale 1ns/1ps
module ocsv_ctrl_poll (
  input wire clock,
  input wire scanUpdated,
  input wire [15:0] rawVolt,
  input wire [15:0] rawCurr,
  output reg [7:0] pollCount_reg,
  output reg signed [31:0] milliVolt_reg,
  output reg signed [31:0] milliAmp_reg
);
  initial pollCount_reg = 8'h00;
  always @(posedge clock)
    if (scanUpdated)
    begin
      pollCount_reg <= pollCount_reg + 8'h01;
      milliVolt_reg <= $signed(rawVolt) * 2;
      milliAmp_reg <= $signed(rawCurr);
    end
endmodule // ocsv_ctrl_poll

// >>> tb/ocsv_status_voter_tb.sv
// Self-checking bench for the status voter
`timescale 1ns/1ps
module ocsv_status_voter_tb;
  reg clock = 1'b0, rst = 1'b1, ce = 1'b1, sliceWrite = 1'b0, sliceScanDone = 1'b0, hkWrite = 1'b0;
  reg [1:0] sliceSel = 2'h0;
  reg [5:0] sliceChan = 6'h00;
  reg [2:0] sliceStateCode = 3'h0, sliceFatal = 3'h0;
  reg [15:0] sliceVolt = 16'h0000, sliceCurr = 16'h0000;
  wire [119:0] stc;
  wire [639:0] vrs, crs;
  wire [39:0] lff;
  wire [15:0] w0, w1, w2;
  wire [911:0] hkv;
  wire upd;
  wire [7:0] polls;
  wire signed [31:0] mv, ma;
  integer err_count = 0, num_checks = 0, i, ch;
  always #5 clock = ~clock;
  // Housekeeping shares select, index and value lines with channel data
  ocsv_status_voter u_dut (.clock(clock), .rst(rst), .ce(ce), .sliceWrite(sliceWrite), .sliceSel(sliceSel),
    .sliceChan(sliceChan), .sliceStateCode(sliceStateCode), .sliceVolt(sliceVolt), .sliceCurr(sliceCurr),
    .sliceScanDone(sliceScanDone), .sliceFatal(sliceFatal), .hkWrite(hkWrite), .hkSel(sliceSel),
    .hkQty(sliceChan[4:0]), .hkValue(sliceVolt), .chanStateCodes(stc), .voltageReadbackSet(vrs),
    .currentReadbackSet(crs), .lineFaultFlags(lff), .sliceDisagreementWord0(w0), .sliceDisagreementWord1(w1),
    .sliceDisagreementWord2(w2), .housekeepingValues(hkv), .scanUpdated(upd));
  ocsv_ctrl_poll u_poll (.clock(clock), .scanUpdated(upd), .rawVolt(vrs[15:0]), .rawCurr(crs[15:0]),
    .pollCount_reg(polls), .milliVolt_reg(mv), .milliAmp_reg(ma));
  task drv(input w, d, h, input [1:0] s, input [5:0] c, input [2:0] st, input [15:0] v, a);
    begin
      @(posedge clock);
      #1;
      sliceWrite = w;
      sliceScanDone = d;
      hkWrite = h;
      sliceSel = s;
      sliceChan = c;
      sliceStateCode = st;
      sliceVolt = v;
      sliceCurr = a;
    end
  endtask
  task wr3(input [5:0] c, input [8:0] st, input [47:0] v, a);
    integer s;
    for (s = 0; s < 3; s = s + 1)
      drv(1'b1, 1'b0, 1'b0, s[1:0], c, st[3*s+:3], v[16*s+:16], a[16*s+:16]);
  endtask
  task chk(input [63:0] nm, input [15:0] e, g);
    begin
      num_checks = num_checks + 1;
      if (g !== e)
      begin
        err_count = err_count + 1;
        $display("ERROR %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task pub(input integer n);
    begin
      for (i = n; i < 3; i = i + 1)
        drv(1'b0, 1'b1, 1'b0, i[1:0], 6'h00, 3'h0, 16'h0000, 16'h0000);
      drv(1'b0, 1'b0, 1'b0, 2'h0, 6'h00, 3'h0, 16'h0000, 16'h0000);
      for (i = 0; i < 9 && upd !== 1'b1; i = i + 1)
      begin
        @(posedge clock);
        #2;
      end
      if (i == 9)
      begin
        err_count = err_count + 1;
        $display("ERROR publish exp 1 got 0");
        wrap_up;
      end
    end
  endtask
  initial
  begin
    repeat (10) @(posedge clock);
    #1;
    rst = 1'b0;
    chk("hk0", 16'h0000, hkv[15:0]);
    for (ch = 1; ch <= 40; ch = ch + 1)
      wr3(ch[5:0], 9'h092, 48'h0, 48'h0);
    wr3(6'h01, 9'h0a4, 48'h012cffce0064, 48'hfe0c07d003e8);
    wr3(6'h02, 9'h0b1, 48'h0, 48'h0);
    wr3(6'h03, 9'h1b6, 48'h0, 48'h0);
    wr3(6'h11, 9'h11b, 48'h0, 48'h0);
    wr3(6'h28, 9'h16d, 48'h830083008300, 48'h7d007d007d00);
    drv(1'b1, 1'b0, 1'b0, 2'h3, 6'h05, 3'h5, 16'h0000, 16'h0000);
    drv(1'b1, 1'b0, 1'b0, 2'h0, 6'h00, 3'h5, 16'h0000, 16'h0000);
    drv(1'b1, 1'b0, 1'b0, 2'h0, 6'h29, 3'h5, 16'h0000, 16'h0000);
    pub(0);
    chk("st1", 16'h0004, (stc >> 0) & 16'h7);
    chk("st2", 16'h0001, (stc >> 3) & 16'h7);
    chk("st3", 16'h0006, (stc >> 6) & 16'h7);
    chk("st5", 16'h0002, (stc >> 12) & 16'h7);
    chk("st17", 16'h0003, (stc >> 48) & 16'h7);
    chk("st40", 16'h0005, (stc >> 117) & 16'h7);
    chk("v1", 16'h0064, vrs[15:0]);
    chk("v40", 16'h8300, vrs[639:624]);
    chk("c1", 16'h09c4, crs[15:0]);
    chk("c40", 16'h7fff, crs[639:624]);
    chk("lfLo", 16'h0000, lff[15:0]);
    chk("lfMid", 16'h0001, lff[31:16]);
    chk("lfHi", 16'h0080, {8'h00, lff[39:32]});
    chk("w0", 16'h0003, w0);
    chk("w1", 16'h0001, w1);
    chk("w2", 16'h0000, w2);
    // The poller latches on the edge after the publish pulse
    @(posedge clock);
    #1;
    chk("mv", 16'h00c8, mv[15:0]);
    chk("ma", 16'h09c4, ma[15:0]);
    // Repeated done and a missing slice must not publish
    drv(1'b0, 1'b1, 1'b0, 2'h0, 6'h00, 3'h0, 16'h0000, 16'h0000);
    drv(1'b0, 1'b1, 1'b0, 2'h0, 6'h00, 3'h0, 16'h0000, 16'h0000);
    drv(1'b0, 1'b1, 1'b0, 2'h1, 6'h00, 3'h0, 16'h0000, 16'h0000);
    drv(1'b1, 1'b0, 1'b0, 2'h2, 6'h01, 3'h4, 16'h0200, 16'h0000);
    drv(1'b0, 1'b0, 1'b0, 2'h0, 6'h00, 3'h0, 16'h0000, 16'h0000);
    repeat (4)
    begin
      @(posedge clock);
      #2;
      chk("noPub", 16'h0000, {15'h0000, upd});
    end
    pub(2);
    chk("w0b", 16'h0002, w0);
    chk("c1b", 16'h0bb8, crs[15:0]);
    @(posedge clock);
    #1;
    chk("polls", 16'h0002, {8'h00, polls});
    // A housekeeping write while frozen must not land; hk3 below sees it
    ce = 1'b0;
    drv(1'b0, 1'b0, 1'b1, 2'h0, 6'h01, 3'h0, 16'h5555, 16'h0000);
    drv(1'b0, 1'b0, 1'b0, 2'h0, 6'h00, 3'h0, 16'h0000, 16'h0000);
    ce = 1'b1;
    drv(1'b0, 1'b0, 1'b1, 2'h2, 6'h09, 3'h0, 16'h1900, 16'h0000);
    drv(1'b0, 1'b0, 1'b1, 2'h0, 6'h12, 3'h0, 16'h8000, 16'h0000);
    drv(1'b0, 1'b0, 1'b1, 2'h0, 6'h13, 3'h0, 16'h1234, 16'h0000);
    drv(1'b0, 1'b0, 1'b1, 2'h3, 6'h00, 3'h0, 16'h5678, 16'h0000);
    drv(1'b0, 1'b0, 1'b0, 2'h0, 6'h00, 3'h0, 16'h0000, 16'h0000);
    chk("hk29", 16'h1900, hkv[479:464]);
    chk("hk54", 16'h8000, hkv[879:864]);
    chk("hk3", 16'h0000, hkv[63:48]);
    sliceFatal = 3'h4;
    @(posedge clock);
    #1;
    chk("hk29f", 16'h0000, hkv[479:464]);
    chk("hk54k", 16'h8000, hkv[879:864]);
    sliceFatal = 3'h5;
    @(posedge clock);
    #1;
    chk("hk54f", 16'h0000, hkv[879:864]);
    wrap_up;
  end
endmodule // ocsv_status_voter_tb
